// ---- sim/sfid_host.sv ----
`timescale 1ns/10ps
module sfid_host (
    output reg sclk,
    output reg cs_n,
    output reg [3:0] io,
    input wire [3:0] io_out,
    input wire [3:0] oe_n
);
    reg drove = 1'b0;
    initial {sclk, cs_n, io} = 6'h10;
    task xfer(input integer w, input integer n, input [63:0] tx, output [63:0] rx);
        integer i;
        begin
            rx = 64'h0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                io = 4'(tx >> (i * w)) & 4'((1 << w) - 1);
                #500 sclk = 1'b1;
                // a released lane reads inverted, so a missing enable shows
                rx = (rx << w) | 64'((w == 1) ? {3'h0, io_out[1] ^ oe_n[1]} : (io_out ^ oe_n) & 4'((1 << w) - 1));
                drove = drove | (oe_n !== 4'hF);
                #500 sclk = 1'b0;
            end
        end
    endtask
    // select rises only after a whole clock
    task run(output [63:0] rx, input [7:0] c, input integer w, input integer n, input [63:0] a,
            input integer r, input integer d = 0, input [63:0] b = 64'h0);
        begin
            drove = 1'b0;
            cs_n = 1'b0;
            #500 xfer(1, 8, {56'h0, c}, rx);
            if (n > 0) xfer(w, n, a, rx);
            if (d > 0) xfer(w, d, b, rx);
            if (r > 0) xfer(w, r, 64'h0, rx);
            // flipped so a released lane never repeats its last bit
            io = ~io;
            #500 cs_n = 1'b1;
            #1000;
        end
    endtask
endmodule // sfid_host

// ---- sim/sfid_monitor.sv ----
`timescale 1ns/10ps
module sfid_monitor (
    input wire clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire [3:0] spi_io_in,
    input wire [3:0] spi_io_out,
    input wire [3:0] spi_io_oe_n,
    input wire write_enable_latch,
    input wire [3:0] otp_lock_bits,
    input wire ext_busy,
    input wire otp_busy,
    input wire wel_clear
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_oe_idle: assert property (spi_cs_n [*8] |-> spi_io_oe_n == 4'hF) else $error("lanes driven");
    chk_oe_release: assert property ($rose(spi_cs_n) |-> ##[1:6] spi_io_oe_n == 4'hF) else $error("late");
    chk_oe_code: assert property (spi_io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("enable");
    chk_clear_cause: assert property (wel_clear |-> !otp_busy && $past(otp_busy)) else $error("clear");
    chk_clear_single: assert property (wel_clear |=> !wel_clear) else $error("long clear");
    chk_busy_end: assert property ($fell(otp_busy) |-> wel_clear) else $error("no clear");
    chk_busy_start: assert property ($rose(otp_busy) |-> spi_cs_n && write_enable_latch) else $error("start");
    chk_busy_hold: assert property ($rose(otp_busy) |=> otp_busy [*8]) else $error("short");
endmodule // sfid_monitor
bind sfid_top sfid_monitor u_mon (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_io_in(spi_io_in), .spi_io_out(spi_io_out), .spi_io_oe_n(spi_io_oe_n),
    .write_enable_latch(write_enable_latch), .otp_lock_bits(otp_lock_bits), .ext_busy(ext_busy),
    .otp_busy(otp_busy), .wel_clear(wel_clear));

// ---- sim/spi_flash_id_and_otp_regs_bench.sv ----
`timescale 1ns/10ps
`include "sfid_map.vh"
module spi_flash_id_and_otp_regs_bench;
    reg clk, rst_n, latch, ext_busy, seen;
    reg [3:0] lock;
    wire sclk, cs_n, busy, wel_clear;
    wire [3:0] io_in, io_out, oe_n;
    integer errors = 0, n_tests = 0, k, busy_n = 0, busy_0 = 0;
    reg [63:0] rx, e;
    reg [23:0] pd;
    reg [7:0] mem [0:1023];
    sfid_top u_dut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_io_in(io_in),
        .spi_io_out(io_out), .spi_io_oe_n(oe_n), .write_enable_latch(latch), .otp_lock_bits(lock),
        .ext_busy(ext_busy), .otp_busy(busy), .wel_clear(wel_clear));
    sfid_host h (.sclk(sclk), .cs_n(cs_n), .io(io_in), .io_out(io_out), .oe_n(oe_n));
    always #50 clk = ~clk;
    // latch drops when the cycle ends
    always @(posedge clk) if (wel_clear) latch <= 1'b0;
    always @(posedge clk) if (busy === 1'b1) busy_n <= busy_n + 1;
    ////////////////////////////////////////////////////////////
    task chk(input [63:0] got, input [63:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d tests %0d", errors, n_tests);
            if (errors == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // waits past the longest self-timed cycle
    task done(input integer nb);
        begin
            seen = 1'b0;
            repeat (1200) @(posedge clk) seen = seen | (wel_clear === 1'b1);
            #10 chk(seen, nb > 0);
            chk(busy_n - busy_0, nb);
            busy_0 = busy_n;
        end
    endtask
    task rdchk(input [9:0] p);
        begin
            h.run(rx, 8'h48, 1, 24, {10'h0, p[9:8], 4'h0, p[7:0]}, 32, 8);
            e = 64'h0;
            for (k = 0; k < 4; k = k + 1)
                e = {e[55:0], mem[{p[9:8], p[7:0] + k[7:0]}]};
            chk(rx, e);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, latch, ext_busy, lock} = 8'h08;
        for (k = 0; k < 1024; k = k + 1)
            mem[k] = 8'hFF;
        k = $urandom(32'heb5d);
        repeat (6) @(posedge clk);
        #10 rst_n = 1'b1;
        #1000;
        h.run(rx, 8'h90, 1, 24, 0, 32);
        chk(rx, {2{`SFID_MFR_ID, `SFID_DEV_ID}});
        h.run(rx, 8'h90, 1, 24, 1, 16);
        chk(rx, {`SFID_DEV_ID, `SFID_MFR_ID});
        h.run(rx, 8'h92, 2, 16, 32'hF0, 8);
        chk(rx, {`SFID_MFR_ID, `SFID_DEV_ID});
        h.run(rx, 8'h94, 4, 8, 32'h1F5, 4, 4);
        chk(rx, {`SFID_DEV_ID, `SFID_MFR_ID});
        h.run(rx, 8'h4B, 1, 0, 0, 64, 32);
        chk(rx, `SFID_UNIQUE_ID);
        h.run(rx, 8'h9F, 1, 0, 0, 24);
        chk(rx, {`SFID_MFR_ID, `SFID_MEM_TYPE, `SFID_CAPACITY});
        ext_busy = 1'b1;
        h.run(rx, 8'h48, 1, 24, 0, 16, 8);
        chk(h.drove, 1'b0);
        ext_busy = 1'b0;
        pd = 24'($urandom);
        latch = 1'b1;
        h.run(rx, 8'h42, 1, 24, 32'h10FE, 0, 24, pd);
        done(`SFID_PROG_LAST + 1);
        for (k = 0; k < 3; k = k + 1)
            mem[{2'h1, 8'hFE + k[7:0]}] &= pd[23 - 8 * k -: 8];
        rdchk(10'h1FE);
        latch = 1'b1;
        h.run(rx, 8'h42, 1, 24, 32'h30FE, 0, 24, pd);
        done(1'b0);
        h.run(rx, 8'h44, 1, 24, 32'h3000, 0);
        done(1'b0);
        rdchk(10'h3FE);
        h.run(rx, 8'h44, 1, 25, 32'h2000, 0);
        done(1'b0);
        latch = 1'b0;
        h.run(rx, 8'h44, 1, 24, 32'h1000, 0);
        done(1'b0);
        latch = 1'b1;
        h.run(rx, 8'h44, 1, 24, 32'h1000, 0);
        done(`SFID_ERASE_LAST + 1);
        for (k = 256; k < 512; k = k + 1)
            mem[k] = 8'hFF;
        rdchk(10'h1FE);
        give_verdict;
    end
    initial begin
        #6000000;
        errors = errors + 1;
        give_verdict;
    end
endmodule // spi_flash_id_and_otp_regs_bench

// ---- src/sfid_map.vh ----
`ifndef SFID_MAP_VH
`define SFID_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// instruction codes
`define SFID_CMD_ID 8'h90
`define SFID_CMD_ID_DUAL 8'h92
`define SFID_CMD_ID_QUAD 8'h94
`define SFID_CMD_UID 8'h4B
`define SFID_CMD_JEDEC 8'h9F
`define SFID_CMD_OTP_ERASE 8'h44
`define SFID_CMD_OTP_PROG 8'h42
`define SFID_CMD_OTP_READ 8'h48

////////////////////////////////////////////////////////////////////////////////
// lane width codes
`define SFID_LANE_1 2'h0
`define SFID_LANE_2 2'h1
`define SFID_LANE_4 2'h2

////////////////////////////////////////////////////////////////////////////////
// serial clock counts after the instruction byte
`define SFID_ADDR_CLKS_1 6'h18
`define SFID_ADDR_MODE_CLKS_2 6'h10
`define SFID_ADDR_MODE_CLKS_4 6'h08
`define SFID_QUAD_ID_TOTAL_CLKS 6'h0C
`define SFID_UID_DUMMY_CLKS 6'h20
`define SFID_OTP_READ_TOTAL_CLKS 6'h20
`define SFID_NO_SHIFT_CLKS 6'h00

////////////////////////////////////////////////////////////////////////////////
// identification values, arbitrary except the R2 swap address
`define SFID_ID_SWAP_ADDR 24'h00_0001
`define SFID_MFR_ID 8'h5A
`define SFID_DEV_ID 8'h12
`define SFID_MEM_TYPE 8'h60
`define SFID_CAPACITY 8'h13
`define SFID_UNIQUE_ID 64'h0123_4567_89AB_CDEF

////////////////////////////////////////////////////////////////////////////////
// security register array
`define SFID_OTP_ERASED 8'hFF
`define SFID_ERASE_LAST 16'h03E7
`define SFID_PROG_LAST 16'h00C7

////////////////////////////////////////////////////////////////////////////////
// output enables, active low per lane
`define SFID_OE_N_OFF 4'hF
`define SFID_OE_N_1 4'hD
`define SFID_OE_N_2 4'hC
`define SFID_OE_N_4 4'h0

`endif

// ---- src/sfid_otp_mem.v ----
`timescale 1ns/10ps
`include "sfid_map.vh"
module sfid_otp_mem (
    input wire clk,
    input wire rst_n,
    input wire we,
    input wire [9:0] waddr,
    input wire [7:0] wdata,
    input wire [9:0] raddr,
    output wire [7:0] rdata
);
    // four registers of 256 bytes; flops stand in for the nonvolatile cells
    reg [7:0] mem_r [0:1023];
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 1024; i = i + 1) begin
                mem_r[i] <= `SFID_OTP_ERASED;
            end
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    assign rdata = mem_r[raddr];
endmodule // sfid_otp_mem

// ---- src/sfid_sync.v ----
`timescale 1ns/10ps
module sfid_sync #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // sfid_sync

// ---- src/sfid_top.v ----
`timescale 1ns/10ps
`include "sfid_map.vh"
// Notes on behaviour
// R1: 90h, zero address: maker then device byte.
// R2: address 000001h: device byte comes first.
// R3: ID bytes alternate until chip select rises.
// R4: 92h: address, mode, output two bits.
// R5: 94h: quad address, mode, four dummies.
// R6: host sends mode byte Fxh.
// R7: 4Bh: four dummy bytes, 64-bit ID.
// R8: 9Fh: maker, memory type, capacity bytes.
// R9: four 256-byte registers, address field layout.
// R10: erase 44h needs write enable latch.
// R11: erase needs chip select at byte boundary.
// R12: self-timed erase shows busy until done.
// R13: erase completion clears write enable latch.
// R14: lock bit set marks register locked.
// R15: erase to locked register is ignored.
// R16: program 42h needs latch, 1-256 bytes.
// R17: program to locked register is ignored.
// R18: read 48h: address, eight dummies, data.
// R19: read offset wraps FFh to 00h.
// R20: read while busy is ignored.
// R21: host should use registers 1-3 first.
// R22: outputs float except during read output.
module sfid_top (
    input wire clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire [3:0] spi_io_in,
    output wire [3:0] spi_io_out,
    output wire [3:0] spi_io_oe_n,
    input wire write_enable_latch,
    input wire [3:0] otp_lock_bits,
    input wire ext_busy,
    output wire otp_busy,
    output wire wel_clear
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_CMD = 6'h02;
    localparam [5:0] ST_ADDR = 6'h04;
    localparam [5:0] ST_OUT = 6'h08;
    localparam [5:0] ST_PROG = 6'h10;
    localparam [5:0] ST_SKIP = 6'h20;

    reg [1:0] rst_ff_r;
    wire rst_s_n;
    wire [5:0] pin_q;
    wire sclk_s;
    wire cs_s;
    wire [3:0] io_s;
    reg sclk_d_r;
    reg cs_d_r;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;
    reg [5:0] state_r;
    reg [7:0] cmd_r;
    reg [31:0] sh_r;
    reg [2:0] bit_cnt_r;
    reg [5:0] in_cnt_r;
    reg [5:0] shift_n_r;
    reg [5:0] total_n_r;
    reg [1:0] lane_r;
    reg [23:0] addr_r;
    reg [7:0] idx_r;
    reg ord_r;
    reg [7:0] out_sh_r;
    reg [2:0] out_cnt_r;
    reg first_r;
    reg [3:0] io_out_r;
    reg [3:0] oe_n_r;
    reg over_r;
    reg ers_ok_r;
    reg prog_ok_r;
    reg prog_any_r;
    reg busy_r;
    reg erasing_r;
    reg [1:0] ers_reg_r;
    reg [15:0] timer_r;
    reg [15:0] op_last_r;
    reg wel_clear_r;
    reg mem_we_r;
    reg [9:0] mem_wa_r;
    reg [7:0] mem_wd_r;
    wire [7:0] mem_rd;
    wire [9:0] mem_ra;
    wire [7:0] rd_off;
    wire busy_all;
    wire [31:0] nsh;
    wire [31:0] a_sh;
    wire [23:0] a_fin;
    wire a_ok;
    reg [7:0] next_byte;
    wire [63:0] uid_sh;

    ////////////////////////////////////////////////////////////////////////////
    function [31:0] shift_in;
        input [31:0] s;
        input [3:0] io;
        input [1:0] w;
        begin
            case (w)
                `SFID_LANE_1: shift_in = {s[30:0], io[0]};
                `SFID_LANE_2: shift_in = {s[29:0], io[1:0]};
                default: shift_in = {s[27:0], io};
            endcase
        end
    endfunction

    function [3:0] out_chunk;
        input [7:0] b;
        input [1:0] w;
        begin
            case (w)
                `SFID_LANE_1: out_chunk = {2'h0, b[7], 1'b0};
                `SFID_LANE_2: out_chunk = {2'h0, b[7:6]};
                default: out_chunk = b[7:4];
            endcase
        end
    endfunction

    function [7:0] shift_out;
        input [7:0] b;
        input [1:0] w;
        begin
            case (w)
                `SFID_LANE_1: shift_out = {b[6:0], 1'b0};
                `SFID_LANE_2: shift_out = {b[5:0], 2'h0};
                default: shift_out = {b[3:0], 4'h0};
            endcase
        end
    endfunction

    function [3:0] oe_mask;
        input [1:0] w;
        begin
            case (w)
                `SFID_LANE_1: oe_mask = `SFID_OE_N_1;
                `SFID_LANE_2: oe_mask = `SFID_OE_N_2;
                default: oe_mask = `SFID_OE_N_4;
            endcase
        end
    endfunction

    function [2:0] last_chunk;
        input [1:0] w;
        begin
            case (w)
                `SFID_LANE_1: last_chunk = 3'h7;
                `SFID_LANE_2: last_chunk = 3'h3;
                default: last_chunk = 3'h1;
            endcase
        end
    endfunction

    // R9: high byte zero, register in 15:12 below 4, 11:8 zero
    function otp_addr_ok;
        input [23:0] a;
        begin
            otp_addr_ok = (a[23:14] == 10'h000) && (a[11:8] == 4'h0);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff_r <= 2'h0;
        end else begin
            rst_ff_r <= {rst_ff_r[0], 1'b1};
        end
    end
    assign rst_s_n = rst_ff_r[1];

    // sclk starts at its idle low level, so reset leaves no false edge
    sfid_sync #(.WIDTH(6), .INIT(6'h1F)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_s_n),
        .d({spi_sclk, spi_cs_n, spi_io_in}),
        .q(pin_q)
    );
    assign sclk_s = pin_q[5];
    assign cs_s = pin_q[4];
    assign io_s = pin_q[3:0];

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
        end
    end
    // serial clock must stay well below clk/4 for edges to be seen
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign cs_rise = cs_s & ~cs_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // address path and security register storage
    assign busy_all = busy_r | ext_busy;
    assign nsh = shift_in(sh_r, io_s, lane_r);
    assign a_sh = (in_cnt_r < shift_n_r) ? nsh : sh_r;
    assign a_fin = (lane_r == `SFID_LANE_1) ? a_sh[23:0] : a_sh[31:8];
    assign a_ok = write_enable_latch && otp_addr_ok(a_fin) && !otp_lock_bits[a_fin[13:12]];
    // R19: 8-bit offset sum wraps inside the register
    assign rd_off = addr_r[7:0] + idx_r;
    assign uid_sh = `SFID_UNIQUE_ID >> {~idx_r[2:0], 3'h0};
    assign mem_ra = erasing_r ? {ers_reg_r, timer_r[7:0]} : {addr_r[13:12], rd_off};

    sfid_otp_mem u_otp_mem (
        .clk(clk),
        .rst_n(rst_s_n),
        .we(mem_we_r),
        .waddr(mem_wa_r),
        .wdata(mem_wd_r),
        .raddr(mem_ra),
        .rdata(mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // byte to send next
    always @* begin
        next_byte = 8'h00;
        case (cmd_r)
            // R3: alternate without limit
            `SFID_CMD_ID, `SFID_CMD_ID_DUAL, `SFID_CMD_ID_QUAD: begin
                next_byte = (idx_r[0] ^ ord_r) ? `SFID_DEV_ID : `SFID_MFR_ID;
            end
            // R8: three fixed bytes
            `SFID_CMD_JEDEC: begin
                if (idx_r == 8'h00) begin
                    next_byte = `SFID_MFR_ID;
                end else if (idx_r == 8'h01) begin
                    next_byte = `SFID_MEM_TYPE;
                end else if (idx_r == 8'h02) begin
                    next_byte = `SFID_CAPACITY;
                end
            end
            // R7: 64-bit identifier, top byte first
            `SFID_CMD_UID: begin
                if (idx_r[7:3] == 5'h00) begin
                    next_byte = uid_sh[7:0];
                end
            end
            `SFID_CMD_OTP_READ: next_byte = mem_rd;
            default: next_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction sequencer
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_r <= ST_IDLE;
            cmd_r <= 8'h00;
            sh_r <= 32'h0000_0000;
            bit_cnt_r <= 3'h0;
            in_cnt_r <= 6'h00;
            shift_n_r <= 6'h00;
            total_n_r <= 6'h00;
            lane_r <= `SFID_LANE_1;
            addr_r <= 24'h00_0000;
            idx_r <= 8'h00;
            ord_r <= 1'b0;
            out_sh_r <= 8'h00;
            out_cnt_r <= 3'h0;
            first_r <= 1'b0;
            io_out_r <= 4'h0;
            oe_n_r <= `SFID_OE_N_OFF;
            over_r <= 1'b0;
            ers_ok_r <= 1'b0;
            prog_ok_r <= 1'b0;
            prog_any_r <= 1'b0;
            busy_r <= 1'b0;
            erasing_r <= 1'b0;
            ers_reg_r <= 2'h0;
            timer_r <= 16'h0000;
            op_last_r <= 16'h0000;
            wel_clear_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_wa_r <= 10'h000;
            mem_wd_r <= 8'h00;
        end else begin
            mem_we_r <= 1'b0;
            wel_clear_r <= 1'b0;
            // R12: self-timed operation, busy until the last count
            if (busy_r) begin
                if (erasing_r && timer_r[15:8] == 8'h00) begin
                    mem_we_r <= 1'b1;
                    mem_wa_r <= {ers_reg_r, timer_r[7:0]};
                    mem_wd_r <= `SFID_OTP_ERASED;
                end
                timer_r <= timer_r + 16'h0001;
                if (timer_r == op_last_r) begin
                    busy_r <= 1'b0;
                    erasing_r <= 1'b0;
                    // R13: latch cleared as the operation ends
                    wel_clear_r <= 1'b1;
                end
            end
            if (cs_s) begin
                // R22: release all lanes with chip select
                state_r <= ST_IDLE;
                oe_n_r <= `SFID_OE_N_OFF;
                io_out_r <= 4'h0;
                if (cs_rise) begin
                    // R11: erase only when no clock followed the address
                    if (state_r == ST_SKIP && cmd_r == `SFID_CMD_OTP_ERASE && !over_r && ers_ok_r) begin
                        busy_r <= 1'b1;
                        erasing_r <= 1'b1;
                        ers_reg_r <= addr_r[13:12];
                        timer_r <= 16'h0000;
                        op_last_r <= `SFID_ERASE_LAST;
                    end else if (state_r == ST_PROG && prog_ok_r && prog_any_r && bit_cnt_r == 3'h0) begin
                        busy_r <= 1'b1;
                        timer_r <= 16'h0000;
                        op_last_r <= `SFID_PROG_LAST;
                    end
                end
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        state_r <= ST_CMD;
                        bit_cnt_r <= 3'h0;
                        lane_r <= `SFID_LANE_1;
                        sh_r <= 32'h0000_0000;
                    end
                    ST_CMD: if (sclk_rise) begin
                        sh_r <= nsh;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            cmd_r <= nsh[7:0];
                            in_cnt_r <= 6'h00;
                            idx_r <= 8'h00;
                            sh_r <= 32'h0000_0000;
                            state_r <= ST_ADDR;
                            // verdicts of the last instruction must not start a new cycle
                            ers_ok_r <= 1'b0;
                            prog_ok_r <= 1'b0;
                            prog_any_r <= 1'b0;
                            lane_r <= `SFID_LANE_1;
                            shift_n_r <= `SFID_ADDR_CLKS_1;
                            total_n_r <= `SFID_ADDR_CLKS_1;
                            case (nsh[7:0])
                                // R1: single-line address
                                `SFID_CMD_ID: lane_r <= `SFID_LANE_1;
                                // R4: two bits per clock
                                `SFID_CMD_ID_DUAL: begin
                                    lane_r <= `SFID_LANE_2;
                                    shift_n_r <= `SFID_ADDR_MODE_CLKS_2;
                                    total_n_r <= `SFID_ADDR_MODE_CLKS_2;
                                end
                                // R5: four bits per clock, four dummies
                                `SFID_CMD_ID_QUAD: begin
                                    lane_r <= `SFID_LANE_4;
                                    shift_n_r <= `SFID_ADDR_MODE_CLKS_4;
                                    total_n_r <= `SFID_QUAD_ID_TOTAL_CLKS;
                                end
                                `SFID_CMD_UID: begin
                                    shift_n_r <= `SFID_NO_SHIFT_CLKS;
                                    total_n_r <= `SFID_UID_DUMMY_CLKS;
                                end
                                `SFID_CMD_JEDEC: begin
                                    state_r <= ST_OUT;
                                    first_r <= 1'b1;
                                end
                                // R10: busy skips here; the latch is checked only at the address end
                                `SFID_CMD_OTP_ERASE, `SFID_CMD_OTP_PROG: begin
                                    if (busy_all) begin
                                        state_r <= ST_SKIP;
                                    end
                                end
                                // R20: read refused while busy
                                `SFID_CMD_OTP_READ: begin
                                    total_n_r <= `SFID_OTP_READ_TOTAL_CLKS;
                                    if (busy_all) begin
                                        state_r <= ST_SKIP;
                                    end
                                end
                                default: state_r <= ST_SKIP;
                            endcase
                        end
                    end
                    // R18: address then dummies, sampled on rising edges
                    ST_ADDR: if (sclk_rise) begin
                        if (in_cnt_r < shift_n_r) begin
                            sh_r <= nsh;
                        end
                        in_cnt_r <= in_cnt_r + 6'h01;
                        if (in_cnt_r == total_n_r - 6'h01) begin
                            addr_r <= a_fin;
                            // R2: swapped order on address one
                            ord_r <= (a_fin == `SFID_ID_SWAP_ADDR);
                            idx_r <= 8'h00;
                            bit_cnt_r <= 3'h0;
                            sh_r <= 32'h0000_0000;
                            over_r <= 1'b0;
                            first_r <= 1'b1;
                            // R14: lock bits block erase and program
                            ers_ok_r <= a_ok;
                            prog_ok_r <= a_ok;
                            prog_any_r <= 1'b0;
                            if (cmd_r == `SFID_CMD_OTP_ERASE) begin
                                state_r <= ST_SKIP;
                            end else if (cmd_r == `SFID_CMD_OTP_PROG) begin
                                state_r <= ST_PROG;
                            end else begin
                                state_r <= ST_OUT;
                            end
                        end
                    end
                    // R16: data bytes while chip select stays low
                    ST_PROG: if (sclk_rise) begin
                        sh_r <= nsh;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            idx_r <= idx_r + 8'h01;
                            prog_any_r <= 1'b1;
                            // R17: locked register left unchanged
                            if (prog_ok_r) begin
                                mem_we_r <= 1'b1;
                                mem_wa_r <= {addr_r[13:12], rd_off};
                                mem_wd_r <= mem_rd & nsh[7:0];
                            end
                        end
                    end
                    // R15: refused commands wait for chip select
                    ST_SKIP: if (sclk_rise) begin
                        over_r <= 1'b1;
                    end
                    ST_OUT: if (sclk_fall) begin
                        oe_n_r <= oe_mask(lane_r);
                        if (first_r || out_cnt_r == 3'h0) begin
                            io_out_r <= out_chunk(next_byte, lane_r);
                            out_sh_r <= shift_out(next_byte, lane_r);
                            out_cnt_r <= last_chunk(lane_r);
                            idx_r <= idx_r + 8'h01;
                            first_r <= 1'b0;
                        end else begin
                            io_out_r <= out_chunk(out_sh_r, lane_r);
                            out_sh_r <= shift_out(out_sh_r, lane_r);
                            out_cnt_r <= out_cnt_r - 3'h1;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    assign spi_io_out = io_out_r;
    assign spi_io_oe_n = oe_n_r;
    assign otp_busy = busy_r;
    assign wel_clear = wel_clear_r;
endmodule // sfid_top
